// >>> design/spta_serial_engine.sv
// Behaviour
// RULE_01 - All table read forms arrive as 4-bit special codes, never 16-bit.
// RULE_02 - Next 4-bit code shifts in while previous executes; forced no-op after reset.
// RULE_03 - Table read releases CPU eight clocks, loading addressed byte into table latch.
// RULE_04 - Then eight suspended clocks drive data pin, latch shifted out LSb first.
// RULE_05 - After eight read bits, four clocks prefetch the next 4-bit code.
// RULE_06 - Bits gather in a shift register; act only on complete commands.
// RULE_07 - Programmer resets address by literal zero written to all pointer bytes.
// RULE_08 - Programmer loads 22-bit address with three literal and file-write pairs.
// RULE_09 - Each rising clock edge right-shifts data in; count 4 or 16.
// RULE_10 - Table write stores all 16 data bits into one program word.
// RULE_11 - The 16 write bits are captured into latch and buffer as word; the 8-bit latch takes only the low byte.
// RULE_12 - Word selected whether pointer holds its even or odd byte.
// RULE_13 - Programmer verifies high then low byte, repeating write on mismatch.
// RULE_14 - Table write supports none, post-inc, post-dec and pre-inc pointer modes.
// RULE_15 - Table write to odd or even address starts a long write.
// RULE_16 - Table read with no change leaves the pointer untouched.
// RULE_17 - After eight read bits the next code comes in four clocks.
// RULE_18 - Programmer over-programs with three times the pulses needed.
// RULE_19 - Write data is the 16 bits following the table write code.
// RULE_20 - Codes 0000 no-op, 10xx read, 11xx write; others act as no-op.
// RULE_21 - No-op code: CPU suspended 16 clocks for core word, then executes.
// RULE_22 - Programming lasts while clock pin high; stops when it falls.
module spta_serial_engine
	import spta_pkg::*;
#(
	parameter int MEM_ADDR_W = 12
) (
	// System clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// Mode entry level
	input  wire logic                   serial_program_mode,
	// Link pins
	input  wire logic                   serial_clock_pin,
	input  wire logic                   serial_data_in,
	output logic                        serial_data_out,
	output logic                        serial_data_oe,
	// Status
	output logic                        cpu_released,
	output logic                        programming_active,
	output logic      [SPTA_PTR_W-1:0]  table_pointer,
	output logic      [SPTA_BYTE_W-1:0] table_latch,
	output logic      [SPTA_BYTE_W-1:0] work_reg
);

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (MEM_ADDR_W < 1 || MEM_ADDR_W > SPTA_PTR_W - 1) begin : g_bad_depth
		$error("MEM_ADDR_W out of range");
	end

	// Pointer step for pre or post phase of a mode
	function automatic logic [SPTA_PTR_W-1:0] ptr_step(
		input logic [SPTA_PTR_W-1:0] ptr,
		input spta_ptr_mode_type     mode,
		input logic                  pre
	);
		logic [SPTA_PTR_W-1:0] res;
		res = ptr;
		if (pre && mode == SPTA_PM_PRE_INC) begin
			res = ptr + 22'h000001;
		end else if (!pre && mode == SPTA_PM_POST_INC) begin
			res = ptr + 22'h000001;
		end else if (!pre && mode == SPTA_PM_POST_DEC) begin
			res = ptr - 22'h000001;
		end
		return res;
	endfunction

	// ---------------------------------------------------------------
	// Link domain: reset and latch-ready synchronisers
	// ---------------------------------------------------------------
	logic lrst_meta_reg;
	logic lrst_reg;
	logic done_meta_reg;
	logic done_sync_reg;
	logic done_tgl_reg;

	// Leaving the mode also holds the link logic in reset
	always_ff @(posedge serial_clock_pin) begin
		lrst_meta_reg <= rst | ~serial_program_mode;
		lrst_reg      <= lrst_meta_reg;
		done_meta_reg <= done_tgl_reg;
		done_sync_reg <= done_meta_reg;
	end

	// ---------------------------------------------------------------
	// Link domain: serial state machine
	// ---------------------------------------------------------------
	spta_link_state_type    lstate_reg, lstate_next;
	logic [SPTA_CNT_W-1:0]  cnt_reg, cnt_next;
	logic [SPTA_WORD_W-1:0] rx_reg, rx_next;
	logic [SPTA_BYTE_W-1:0] tx_reg, tx_next;
	logic                   oe_reg, oe_next;
	logic                   rel_reg, rel_next;
	spta_ptr_mode_type      lmode_reg, lmode_next;
	spta_req_type           req_reg, req_next;
	logic                   req_tgl_reg, req_tgl_next;
	logic                   done_seen_reg, done_seen_next;
	logic [SPTA_CODE_W-1:0] code;

	// Next state of the link side
	always_comb begin
		lstate_next    = lstate_reg;
		cnt_next       = cnt_reg + 5'h01;
		rx_next        = {serial_data_in, rx_reg[SPTA_WORD_W-1:1]}; // RULE_09 RULE_06
		tx_next        = tx_reg;
		oe_next        = oe_reg;
		lmode_next     = lmode_reg;
		req_next       = req_reg;
		req_tgl_next   = req_tgl_reg;
		done_seen_next = done_seen_reg;
		code           = rx_next[SPTA_WORD_W-1:SPTA_WORD_W-SPTA_CODE_W];
		case (lstate_reg)
			SPTA_L_FETCH: begin
				// Previous command executes while the code arrives
				if (cnt_reg == SPTA_FETCH_LAST) begin // RULE_02 RULE_09
					cnt_next   = '0;
					lmode_next = spta_ptr_mode_type'(code[1:0]);
					if (!code[SPTA_CODE_TABLE_BIT]) begin
						lstate_next = SPTA_L_CORE; // RULE_20 RULE_21
					end else if (code[SPTA_CODE_WRITE_BIT]) begin
						lstate_next = SPTA_L_WDATA; // RULE_14 RULE_19
					end else begin
						// Read is a 4-bit code; start it at once
						lstate_next  = SPTA_L_RD_EXEC; // RULE_01 RULE_03
						req_next     = '{SPTA_REQ_READ,
							spta_ptr_mode_type'(code[1:0]), SPTA_WORD_RESET};
						req_tgl_next = ~req_tgl_reg;
					end
				end
			end
			SPTA_L_CORE: begin
				// Whole 16-bit core word before acting
				if (cnt_reg == SPTA_CORE_LAST) begin // RULE_21 RULE_06
					cnt_next     = '0;
					lstate_next  = SPTA_L_FETCH;
					req_next     = '{SPTA_REQ_CORE, SPTA_PM_NONE, rx_next};
					req_tgl_next = ~req_tgl_reg;
				end
			end
			SPTA_L_WDATA: begin
				// Data word follows the write code directly
				if (cnt_reg == SPTA_WDATA_LAST) begin // RULE_19 RULE_11
					cnt_next     = '0;
					lstate_next  = SPTA_L_FETCH;
					req_next     = '{SPTA_REQ_WRITE, lmode_reg, rx_next};
					req_tgl_next = ~req_tgl_reg;
				end
			end
			SPTA_L_RD_EXEC: begin
				// Eighth clock: take latch and turn pin around
				if (cnt_reg == SPTA_RDEXEC_LAST) begin // RULE_03 RULE_04
					cnt_next       = '0;
					lstate_next    = SPTA_L_RD_OUT;
					oe_next        = 1'b1;
					done_seen_next = done_sync_reg;
					tx_next        = (done_sync_reg != done_seen_reg) ?
						table_latch : SPTA_READ_BLANK;
				end
			end
			SPTA_L_RD_OUT: begin
				// LSb first, one bit per rising edge
				tx_next = {1'b0, tx_reg[SPTA_BYTE_W-1:1]}; // RULE_04
				if (cnt_reg == SPTA_RDOUT_LAST) begin // RULE_05 RULE_17
					cnt_next    = '0;
					lstate_next = SPTA_L_FETCH;
					oe_next     = 1'b0;
				end
			end
			default: begin
				lstate_next = SPTA_L_FETCH;
				cnt_next    = '0;
			end
		endcase
		// CPU runs in fetch, read execution and write first cycle
		rel_next = (lstate_next == SPTA_L_FETCH) || (lstate_next == SPTA_L_RD_EXEC) ||
			(lstate_next == SPTA_L_WDATA && cnt_next < SPTA_WR_EXEC_CLKS); // RULE_03
	end

	// Link side registers
	always_ff @(posedge serial_clock_pin) begin
		if (lrst_reg) begin
			lstate_reg    <= SPTA_L_FETCH;
			cnt_reg       <= '0;
			rx_reg        <= SPTA_WORD_RESET;
			tx_reg        <= SPTA_BYTE_RESET;
			oe_reg        <= 1'b0;
			rel_reg       <= 1'b1;
			lmode_reg     <= SPTA_PM_NONE;
			req_reg       <= '{SPTA_REQ_CORE, SPTA_PM_NONE, SPTA_WORD_RESET};
			req_tgl_reg   <= 1'b0;
			done_seen_reg <= 1'b0;
		end else begin
			lstate_reg    <= lstate_next;
			cnt_reg       <= cnt_next;
			rx_reg        <= rx_next;
			tx_reg        <= tx_next;
			oe_reg        <= oe_next;
			rel_reg       <= rel_next;
			lmode_reg     <= lmode_next;
			req_reg       <= req_next;
			req_tgl_reg   <= req_tgl_next;
			done_seen_reg <= done_seen_next;
		end
	end

	assign serial_data_out = tx_reg[0];
	assign serial_data_oe  = oe_reg;
	assign cpu_released    = rel_reg;

	// ---------------------------------------------------------------
	// System domain: request and clock-level synchronisers
	// ---------------------------------------------------------------
	logic rq_meta_reg;
	logic rq_sync_reg;
	logic ck_meta_reg;
	logic ck_sync_reg;

	// Clock pin is also read as a level for the write pulse
	always_ff @(posedge clk_sys) begin
		rq_meta_reg <= req_tgl_reg;
		rq_sync_reg <= rq_meta_reg;
		ck_meta_reg <= serial_clock_pin;
		ck_sync_reg <= ck_meta_reg;
	end

	// ---------------------------------------------------------------
	// System domain: execution of commands
	// ---------------------------------------------------------------
	spta_sys_state_type     sstate_reg, sstate_next;
	logic                   rq_seen_reg, rq_seen_next;
	logic [SPTA_PTR_W-1:0]  ptr_reg, ptr_next;
	logic [SPTA_BYTE_W-1:0] w_reg, w_next;
	logic [SPTA_BYTE_W-1:0] latch_reg, latch_next;
	logic [SPTA_WORD_W-1:0] buf_reg, buf_next;
	spta_ptr_mode_type      smode_reg, smode_next;
	logic                   done_tgl_next;
	logic                   prog_reg, prog_next;
	logic                   mem_we;
	logic [SPTA_WORD_W-1:0] mem_rdata;

	// Next state of the execution side
	always_comb begin
		sstate_next   = sstate_reg;
		rq_seen_next  = rq_seen_reg;
		ptr_next      = ptr_reg;
		w_next        = w_reg;
		latch_next    = latch_reg;
		buf_next      = buf_reg;
		smode_next    = smode_reg;
		done_tgl_next = done_tgl_reg;
		prog_next     = prog_reg;
		mem_we        = 1'b0;
		case (sstate_reg)
			SPTA_S_IDLE: begin
				// Payload has been stable since the toggle moved
				if (rq_sync_reg != rq_seen_reg) begin
					rq_seen_next = rq_sync_reg;
					smode_next   = req_reg.mode;
					if (req_reg.kind == SPTA_REQ_READ) begin
						ptr_next    = ptr_step(ptr_reg, req_reg.mode, 1'b1);
						sstate_next = SPTA_S_RD_MEM;
					end else if (req_reg.kind == SPTA_REQ_WRITE) begin
						ptr_next    = ptr_step(ptr_reg, req_reg.mode, 1'b1); // RULE_14
						buf_next    = req_reg.word; // RULE_11
						latch_next  = req_reg.word[SPTA_BYTE_W-1:0]; // RULE_11
						sstate_next = SPTA_S_WR_ARM;
					end else if (req_reg.word[15:8] == SPTA_OP_LITERAL_TO_W) begin
						w_next = req_reg.word[7:0];
					end else if (req_reg.word[15:8] == SPTA_OP_W_TO_FILE) begin
						// Pointer bytes written one at a time
						if (req_reg.word[7:0] == SPTA_FILE_PTR_LOW) begin
							ptr_next[7:0] = w_reg;
						end else if (req_reg.word[7:0] == SPTA_FILE_PTR_HIGH) begin
							ptr_next[15:8] = w_reg;
						end else if (req_reg.word[7:0] == SPTA_FILE_PTR_UPPER) begin
							ptr_next[21:16] = w_reg[5:0];
						end
					end
				end
			end
			SPTA_S_RD_MEM: begin
				// Word read is in flight
				sstate_next = SPTA_S_RD_LATCH;
			end
			SPTA_S_RD_LATCH: begin
				// Byte lane from pointer bit 0; none mode keeps pointer
				latch_next    = ptr_reg[0] ? mem_rdata[15:8] : mem_rdata[7:0]; // RULE_03
				ptr_next      = ptr_step(ptr_reg, smode_reg, 1'b0); // RULE_16
				done_tgl_next = ~done_tgl_reg;
				sstate_next   = SPTA_S_IDLE;
			end
			SPTA_S_WR_ARM: begin
				// Long write begins once the clock pin stands high
				if (ck_sync_reg) begin // RULE_15 RULE_22
					mem_we      = 1'b1; // RULE_10
					prog_next   = 1'b1;
					sstate_next = SPTA_S_WR_HOLD;
				end
			end
			SPTA_S_WR_HOLD: begin
				// Falling pin ends the pulse; discharge follows
				if (!ck_sync_reg) begin // RULE_22
					prog_next   = 1'b0;
					ptr_next    = ptr_step(ptr_reg, smode_reg, 1'b0); // RULE_14
					sstate_next = SPTA_S_IDLE;
				end
			end
			default: begin
				sstate_next = SPTA_S_IDLE;
			end
		endcase
	end

	// Execution side registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sstate_reg   <= SPTA_S_IDLE;
			rq_seen_reg  <= 1'b0;
			ptr_reg      <= SPTA_PTR_RESET;
			w_reg        <= SPTA_BYTE_RESET;
			latch_reg    <= SPTA_BYTE_RESET;
			buf_reg      <= SPTA_WORD_RESET;
			smode_reg    <= SPTA_PM_NONE;
			done_tgl_reg <= 1'b0;
			prog_reg     <= 1'b0;
		end else begin
			sstate_reg   <= sstate_next;
			rq_seen_reg  <= rq_seen_next;
			ptr_reg      <= ptr_next;
			w_reg        <= w_next;
			latch_reg    <= latch_next;
			buf_reg      <= buf_next;
			smode_reg    <= smode_next;
			done_tgl_reg <= done_tgl_next;
			prog_reg     <= prog_next;
		end
	end

	// ---------------------------------------------------------------
	// Program memory, word addressed; odd or even byte same word
	// ---------------------------------------------------------------
	spta_word_mem #(
		.DATA_W (SPTA_WORD_W),
		.ADDR_W (MEM_ADDR_W)
	) u_mem (
		.clk_sys (clk_sys),
		.rst     (rst),
		.wr_en   (mem_we),
		.wr_addr (ptr_reg[MEM_ADDR_W:1]), // RULE_12
		.wr_data (buf_reg),
		.rd_addr (ptr_reg[MEM_ADDR_W:1]),
		.rd_data (mem_rdata)
	);

	assign programming_active = prog_reg;
	assign table_pointer      = ptr_reg;
	assign table_latch        = latch_reg;
	assign work_reg           = w_reg;

endmodule

// >>> shared/spta_pkg.sv
package spta_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int SPTA_CODE_W = 4;
	localparam int SPTA_WORD_W = 16;
	localparam int SPTA_BYTE_W = 8;
	localparam int SPTA_PTR_W  = 22;
	localparam int SPTA_CNT_W  = 5;

	// ---------------------------------------------------------------
	// Link clock counts per phase
	// ---------------------------------------------------------------
	localparam logic [SPTA_CNT_W-1:0] SPTA_FETCH_LAST   = 5'h03; // 4 clocks
	localparam logic [SPTA_CNT_W-1:0] SPTA_CORE_LAST    = 5'h0f; // 16 clocks
	localparam logic [SPTA_CNT_W-1:0] SPTA_WDATA_LAST   = 5'h0f; // 16 clocks
	localparam logic [SPTA_CNT_W-1:0] SPTA_RDEXEC_LAST  = 5'h07; // 8 clocks
	localparam logic [SPTA_CNT_W-1:0] SPTA_RDOUT_LAST   = 5'h07; // 8 clocks
	localparam logic [SPTA_CNT_W-1:0] SPTA_WR_EXEC_CLKS = 5'h04; // first cycle

	// ---------------------------------------------------------------
	// 4-bit special codes: bit 3 marks a table op, bit 2 a write
	// ---------------------------------------------------------------
	localparam int SPTA_CODE_TABLE_BIT = 3;
	localparam int SPTA_CODE_WRITE_BIT = 2;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_READ_BLANK = 8'hff;

	// ---------------------------------------------------------------
	// Core instruction decode (opcode in upper byte, operand in lower)
	// ---------------------------------------------------------------
	localparam logic [SPTA_BYTE_W-1:0] SPTA_OP_LITERAL_TO_W = 8'h01;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_OP_W_TO_FILE    = 8'h02;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_FILE_PTR_LOW    = 8'h10;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_FILE_PTR_HIGH   = 8'h11;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_FILE_PTR_UPPER  = 8'h12;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [SPTA_PTR_W-1:0]  SPTA_PTR_RESET   = 22'h000000;
	localparam logic [SPTA_BYTE_W-1:0] SPTA_BYTE_RESET  = 8'h00;
	localparam logic [SPTA_WORD_W-1:0] SPTA_WORD_RESET  = 16'h0000;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SPTA_PM_NONE     = 2'b00,
		SPTA_PM_POST_INC = 2'b01,
		SPTA_PM_POST_DEC = 2'b10,
		SPTA_PM_PRE_INC  = 2'b11
	} spta_ptr_mode_type;

	typedef enum logic [1:0] {
		SPTA_REQ_CORE  = 2'b00,
		SPTA_REQ_READ  = 2'b01,
		SPTA_REQ_WRITE = 2'b10
	} spta_req_kind_type;

	typedef struct packed {
		spta_req_kind_type      kind;
		spta_ptr_mode_type      mode;
		logic [SPTA_WORD_W-1:0] word;
	} spta_req_type;

	typedef enum logic [2:0] {
		SPTA_L_FETCH   = 3'b000,
		SPTA_L_CORE    = 3'b001,
		SPTA_L_WDATA   = 3'b010,
		SPTA_L_RD_EXEC = 3'b011,
		SPTA_L_RD_OUT  = 3'b100
	} spta_link_state_type;

	typedef enum logic [2:0] {
		SPTA_S_IDLE     = 3'b000,
		SPTA_S_RD_MEM   = 3'b001,
		SPTA_S_RD_LATCH = 3'b010,
		SPTA_S_WR_ARM   = 3'b011,
		SPTA_S_WR_HOLD  = 3'b100
	} spta_sys_state_type;

endpackage

// >>> design/spta_word_mem.sv
module spta_word_mem
	import spta_pkg::*;
#(
	parameter int DATA_W = SPTA_WORD_W,
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// Read port, one cycle latency
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] mem_array [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rd_data_reg;

	// Array write, no reset so it maps to RAM
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem_array[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= mem_array[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

endmodule

// >>> dv/spta_serial_engine_properties.sv
module spta_serial_engine_properties
	import spta_pkg::*;
#(
	parameter int MEM_ADDR_W = 12
) (
	// System side
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic                   serial_program_mode,
	// Link pins
	input wire logic                   serial_clock_pin,
	input wire logic                   serial_data_in,
	input wire logic                   serial_data_out,
	input wire logic                   serial_data_oe,
	// Status
	input wire logic                   cpu_released,
	input wire logic                   programming_active,
	input wire logic [SPTA_PTR_W-1:0]  table_pointer,
	input wire logic [SPTA_BYTE_W-1:0] table_latch,
	input wire logic [SPTA_BYTE_W-1:0] work_reg
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// Suspension length, counted in link clocks
	// ----
	logic [4:0] low_cnt_reg;
	logic [4:0] low_cnt_next;

	// Cleared by reset so no unknown count leaks into the check
	always_comb begin
		low_cnt_next = (rst || cpu_released) ? 5'h00 : low_cnt_reg + 5'h01;
	end
	always_ff @(posedge serial_clock_pin) begin
		low_cnt_reg <= low_cnt_next;
	end

	chk_reset_clears: assert property (
		@(posedge clk_sys) rst |=> table_pointer == SPTA_PTR_RESET
		&& work_reg == SPTA_BYTE_RESET && !programming_active)
		else $error("state not cleared by reset");
	chk_pulse_rise: assert property (
		@(posedge clk_sys) disable iff (rst) $rose(programming_active)
		|-> $past(serial_clock_pin) && $past(serial_clock_pin, 2))
		else $error("programming began without clock pin high");
	chk_pulse_fall: assert property (
		@(posedge clk_sys) disable iff (rst) $fell(programming_active)
		|-> !$past(serial_clock_pin) && !$past(serial_clock_pin, 2))
		else $error("programming ended while clock pin high");
	chk_ptr_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		programming_active && $past(programming_active) |-> $stable(table_pointer))
		else $error("pointer moved during programming pulse");
	chk_oe_window: assert property (
		@(posedge serial_clock_pin) disable iff (rst || !serial_program_mode)
		$rose(serial_data_oe) |-> serial_data_oe[*8] ##1 !serial_data_oe)
		else $error("data pin not driven for eight clocks");
	chk_oe_suspend: assert property (
		@(posedge serial_clock_pin) disable iff (rst || !serial_program_mode)
		serial_data_oe |-> !cpu_released)
		else $error("cpu running during shift-out");
	chk_read_exec: assert property (
		@(posedge serial_clock_pin) disable iff (rst || !serial_program_mode)
		$rose(serial_data_oe) |-> $past(cpu_released) && $past(cpu_released, 8))
		else $error("cpu not released before shift-out");
	chk_suspend_len: assert property (
		@(posedge serial_clock_pin) disable iff (rst || !serial_program_mode)
		$rose(cpu_released) |-> low_cnt_reg inside {5'h08, 5'h0c, 5'h10})
		else $error("cpu suspension of wrong length");
endmodule

bind spta_serial_engine spta_serial_engine_properties #(.MEM_ADDR_W(MEM_ADDR_W)) u_props (
	.clk_sys(clk_sys), .rst(rst), .serial_program_mode(serial_program_mode),
	.serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
	.cpu_released(cpu_released), .programming_active(programming_active),
	.table_pointer(table_pointer), .table_latch(table_latch), .work_reg(work_reg));

// >>> dv/spta_prog_model.sv
module spta_prog_model (
	// Link pins
	output logic      serial_clock_pin,
	output logic      data_drv,
	// Device side of data pin
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock idles low between frames
	initial begin
		serial_clock_pin = 1'b0;
		data_drv = 1'b0;
	end

	// One 6 ns link clock, data set up half a period ahead
	task automatic pulse(input logic b);
		data_drv = b;
		#3 serial_clock_pin = 1'b1;
		#3 serial_clock_pin = 1'b0;
	endtask

	// LSb first
	task automatic bits(input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			pulse(v[i]);
		end
	endtask

	// Code, then a 16-bit core word; pause lets the system side finish
	task automatic core(input logic [3:0] c, input logic [15:0] w);
		bits({12'h000, c}, 4);
		bits(w, 16);
		#100;
	endtask

	// Line released while device drives: toggle so stale value never reads back
	task automatic read(input logic [1:0] m, output logic [7:0] b, output logic ok);
		bits({12'h000, 2'b10, m}, 4);
		#100;
		bits(16'h0000, 7);
		ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			data_drv = ~data_drv;
			#3 serial_clock_pin = 1'b1;
			#2 b[i] = serial_data_out;
			ok &= serial_data_oe;
			#1 serial_clock_pin = 1'b0;
		end
		pulse(1'b0);
		#100;
	endtask

	// Last data edge leaves the clock high: programming pulse
	task automatic write_data(input logic [1:0] m, input logic [15:0] w);
		bits({12'h000, 2'b11, m}, 4);
		bits(w, 15);
		data_drv = w[15];
		#3 serial_clock_pin = 1'b1;
	endtask

	// Falling clock ends programming, then discharge time
	task automatic end_pulse();
		serial_clock_pin = 1'b0;
		#200;
	endtask
endmodule

// >>> dv/spta_serial_engine_tb.sv
module spta_serial_engine_tb import spta_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// Design and programmer
	// ----
	logic                   clk_sys;
	logic                   rst;
	logic                   serial_program_mode;
	logic                   serial_clock_pin;
	logic                   data_drv;
	logic                   serial_data_in;
	logic                   serial_data_out;
	logic                   serial_data_oe;
	logic                   cpu_released;
	logic                   programming_active;
	logic [SPTA_PTR_W-1:0]  table_pointer;
	logic [SPTA_BYTE_W-1:0] table_latch;
	logic [SPTA_BYTE_W-1:0] work_reg;
	int                     fail_count;
	int                     checks_done;
	int                     cycles;
	logic [SPTA_PTR_W-1:0]  exp_ptr;
	logic [15:0]            mem [int];

	// Pin level seen by the device: whoever drives it
	assign serial_data_in = serial_data_oe ? serial_data_out : data_drv;

	spta_serial_engine uut (.clk_sys(clk_sys), .rst(rst),
		.serial_program_mode(serial_program_mode), .serial_clock_pin(serial_clock_pin),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .cpu_released(cpu_released),
		.programming_active(programming_active), .table_pointer(table_pointer),
		.table_latch(table_latch), .work_reg(work_reg));
	spta_prog_model prog (.serial_clock_pin(serial_clock_pin), .data_drv(data_drv),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	// Hang guard, far above the expected run of about 1350 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	// ----
	// Helpers
	// ----
	task automatic check(input string what, input logic [21:0] got, input logic [21:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Pointer step of a table op, before (pre) or after the access
	function automatic logic [21:0] step(input logic [21:0] p, input logic [1:0] m,
		input logic pre);
		if (pre && m == 2'b11) return p + 22'h1;
		if (!pre && m == 2'b01) return p + 22'h1;
		if (!pre && m == 2'b10) return p - 22'h1;
		return p;
	endfunction

	task automatic put(input logic [7:0] op, input logic [7:0] arg);
		prog.core(4'h0, {op, arg});
	endtask

	task automatic set_ptr(input logic [21:0] p);
		put(SPTA_OP_LITERAL_TO_W, p[7:0]);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_LOW);
		put(SPTA_OP_LITERAL_TO_W, p[15:8]);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_HIGH);
		put(SPTA_OP_LITERAL_TO_W, {2'b00, p[21:16]});
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_UPPER);
		exp_ptr = p;
		check("pointer load", table_pointer, p);
		check("work reg", 22'(work_reg), 22'(p[21:16]));
	endtask

	// Read one byte; odd pointer gives the high byte of the word
	task automatic rd(input logic [1:0] m);
		logic [7:0] got;
		logic       ok;
		logic [7:0] exp;
		exp_ptr = step(exp_ptr, m, 1'b1);
		exp = exp_ptr[0] ? mem[exp_ptr[12:1]][15:8] : mem[exp_ptr[12:1]][7:0];
		prog.read(m, got, ok);
		exp_ptr = step(exp_ptr, m, 1'b0);
		check("read byte", 22'(got), 22'(exp));
		check("pin driven", 22'(ok), 22'h1);
		check("latch", 22'(table_latch), 22'(exp));
		check("ptr after read", table_pointer, exp_ptr);
	endtask

	task automatic wr(input logic [1:0] m, input logic [15:0] w);
		exp_ptr = step(exp_ptr, m, 1'b1);
		mem[exp_ptr[12:1]] = w;
		prog.write_data(m, w);
		repeat (20) @(posedge clk_sys);
		#1;
		check("pulse on", 22'(programming_active), 22'h1);
		prog.end_pulse();
		exp_ptr = step(exp_ptr, m, 1'b0);
		check("pulse off", 22'(programming_active), 22'h0);
		check("ptr after write", table_pointer, exp_ptr);
		check("latch low byte", 22'(table_latch), 22'(w[7:0]));
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		#1;
		check("oe in reset", 22'(serial_data_oe), 22'h0);
		check("cpu in reset", 22'(cpu_released), 22'h1);
		check("ptr in reset", table_pointer, SPTA_PTR_RESET);
	endtask

	// Address load, upper byte width, reset address, unlisted codes
	task automatic t_address();
		logic [3:0] c;
		set_ptr(22'h3ac537);
		put(SPTA_OP_LITERAL_TO_W, 8'hff);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_UPPER);
		check("upper bits", 22'(table_pointer[21:16]), 22'h3f);
		put(SPTA_OP_LITERAL_TO_W, 8'h00);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_UPPER);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_HIGH);
		put(SPTA_OP_W_TO_FILE, SPTA_FILE_PTR_LOW);
		check("reset address", table_pointer, 22'h0);
		for (int i = 1; i < 8; i += 2) begin
			c = 4'(i);
			prog.core(c, {SPTA_OP_LITERAL_TO_W, 4'h9, c});
			check("no-op code", 22'(work_reg), 22'({4'h9, c}));
		end
	endtask

	// Program, verify high then low, reprogram same word without reload
	task automatic t_write_verify();
		set_ptr(22'h000010);
		wr(2'b11, 16'hc35a);
		rd(2'b10);
		rd(2'b00);
		wr(2'b11, 16'h9e71);
		rd(2'b10);
		rd(2'b01);
		// Verified word gets three more pulses of margin
		repeat (3) wr(2'b00, 16'h9e71);
	endtask

	// Every write mode, then every read mode back-to-back
	task automatic t_modes();
		logic [1:0] wm [4];
		logic [1:0] rm [4];
		wm = '{2'b01, 2'b11, 2'b10, 2'b00};
		rm = '{2'b11, 2'b10, 2'b01, 2'b00};
		set_ptr(22'h000100);
		for (int i = 0; i < 4; i++) begin
			wr(wm[i], 16'h3c00 + 16'(i) * 16'h1111);
		end
		for (int i = 0; i < 4; i++) begin
			rd(rm[i]);
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		serial_program_mode = 1'b1;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		exp_ptr = SPTA_PTR_RESET;
		prog.bits(16'h0000, 4);
		repeat (3) @(posedge clk_sys);
		t_reset();
		@(posedge clk_sys);
		rst <= 1'b0;
		#20;
		// Two link edges still inside the synchroniser's reset
		prog.bits(16'h0000, 2);
		t_address();
		t_write_verify();
		t_modes();
		conclude();
	end
endmodule
